//--- tb/serial_port_select_lock_test.sv
// Bench for spsl_top: register cycles on both host ports.
// Assumes spsl_host drives the select pin.
`define CHK(n,e,v) n_tests++; if ((v) !== (e)) begin $display("unexpected %s exp %h got %h", n, e, v); err_total++; end
module serial_port_select_lock_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, pd = 0, cap = 0, ia, sa, lk, fce;
  spsl_pkg::spsl_req_t iq = '0, sq = '0;
  spsl_pkg::spsl_rsp_t rs;
  logic [3:0] idx;
  logic [7:0] cfg;
  wire pin;
  int err_total = 0, n_tests = 0;
  always #4 clk = ~clk;
  spsl_host hm (.core_clk_in(clk), .pin_out(pin));
  spsl_top uut (.core_clk_in(clk), .rst_b_in(rst_b),
    .port_select_pin_in(pin), .power_down_in(pd), .i2c_req_in(iq),
    .spi_req_in(sq), .cap_en_req_in(cap), .rsp_out(rs),
    .i2c_active_out(ia), .spi_active_out(sa), .port_locked_out(lk),
    .fast_capture_en_out(fce), .cap_reg_idx_out(idx),
    .port_config_reg_out(cfg));
  task cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task rstp;
    rst_b = 0;
    cyc(20);
    rst_b = 1;
    cyc(2);
  endtask
  // Expected reply packed as ack, hit, data
  task acc(bit s, bit w, logic [15:0] a, logic [7:0] d, logic [9:0] e);
    if (s) sq = {w, ~w, a, d};
    else iq = {w, ~w, a, d};
    cyc(1);
    iq = '0;
    sq = '0;
    `CHK("reply", e, rs)
    cyc(1);
  endtask
  task close_out;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    cyc(3000);
    err_total++;
    close_out;
  end
  initial begin
    rstp;
    `CHK("i2c", 1'b1, ia)
    `CHK("cap", 1'b0, fce)
    acc(0, 0, 16'hE707, 8'h00, 10'h35A);
    acc(0, 0, 16'hEBFF, 8'h00, 10'h200);
    acc(0, 1, 16'hEA00, 8'hA4, 10'h300);
    acc(0, 0, 16'hEA00, 8'h00, 10'h3A4);
    `CHK("cfg", 8'hA4, cfg)
    `CHK("lock", 1'b0, lk)
    acc(1, 0, 16'hE707, 8'h00, 10'h000);
    cap = 1;
    cyc(3);
    `CHK("cap", 1'b1, fce)
    `CHK("idx", 4'h2, idx)
    cyc(16);
    `CHK("idx", 4'h2, idx)
    cap = 0;
    hm.pulse3;
    cyc(6);
    `CHK("spi", 1'b1, sa)
    `CHK("i2c", 1'b0, ia)
    acc(1, 1, 16'hE707, 8'h11, 10'h200);
    acc(1, 1, 16'hEA00, 8'h00, 10'h300);
    `CHK("lock", 1'b1, lk)
    acc(1, 0, 16'hE707, 8'h00, 10'h35A);
    rstp;
    `CHK("lock", 1'b0, lk)
    `CHK("spi", 1'b0, sa)
    acc(0, 1, 16'hEA00, 8'h01, 10'h300);
    hm.pulse3;
    cyc(6);
    `CHK("spi", 1'b0, sa)
    `CHK("lock", 1'b1, lk)
    pd = 1;
    cyc(2);
    pd = 0;
    cyc(1);
    `CHK("lock", 1'b0, lk)
    `CHK("cfg", 8'h00, cfg)
    `CHK("i2c", 1'b1, ia)
    close_out;
  end
endmodule

//--- tb/spsl_host.sv
// Host model driving the shared port select pin.
// Assumes the pin idles high between toggles.
module spsl_host (
  input  wire logic core_clk_in,
  output logic      pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin_out = 1'b1;
  task pulse3;
    repeat (3) begin
      @(posedge core_clk_in);
      #1 pin_out = 1'b0;
      repeat (3) @(posedge core_clk_in);
      #1 pin_out = 1'b1;
      repeat (3) @(posedge core_clk_in);
    end
  endtask
endmodule

//--- tb/spsl_top_asserts.sv
// Checker for port choice, lock and reply outputs.
// Assumes binding onto spsl_top; sees its ports only.
module spsl_top_asserts (
  input wire logic                core_clk_in,
  input wire logic                rst_b_in,
  input wire logic                power_down_in,
  input wire spsl_pkg::spsl_req_t i2c_req_in,
  input wire spsl_pkg::spsl_req_t spi_req_in,
  input wire spsl_pkg::spsl_rsp_t rsp_out,
  input wire logic                i2c_active_out,
  input wire logic                spi_active_out,
  input wire logic                port_locked_out,
  input wire logic                fast_capture_en_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_one; !(i2c_active_out && spi_active_out); endproperty
  a_one: assert property (p_one) else $error("dual port");
  property p_cap; fast_capture_en_out |-> i2c_active_out; endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_rst; !$past(rst_b_in) |-> !fast_capture_en_out; endproperty
  a_rst: assert property (p_rst) else $error("cap reset");
  property p_spi; spi_active_out && !power_down_in |=> spi_active_out;
  endproperty
  a_spi: assert property (p_spi) else $error("spi drop");
  property p_hold; port_locked_out && !power_down_in |=> port_locked_out;
  endproperty
  a_hold: assert property (p_hold) else $error("lock drop");
  property p_slk; spi_active_out && spi_req_in.wr && !power_down_in &&
    spi_req_in.addr == 16'hEA00 |=> port_locked_out; endproperty
  a_slk: assert property (p_slk) else $error("spi lock");
  property p_ilk; i2c_active_out && i2c_req_in.wr && i2c_req_in.wdata[0]
    && i2c_req_in.addr == 16'hEA00 && !power_down_in |=> port_locked_out;
  endproperty
  a_ilk: assert property (p_ilk) else $error("i2c lock");
  property p_bar; i2c_active_out && port_locked_out && !power_down_in
    |=> !spi_active_out; endproperty
  a_bar: assert property (p_bar) else $error("spi switch");
  property p_ver; i2c_active_out && i2c_req_in.rd &&
    i2c_req_in.addr == 16'hE707 |=> rsp_out == 10'h35A; endproperty
  a_ver: assert property (p_ver) else $error("version");
endmodule
bind spsl_top spsl_top_asserts chk (.core_clk_in, .rst_b_in,
  .power_down_in, .i2c_req_in, .spi_req_in, .rsp_out, .i2c_active_out,
  .spi_active_out, .port_locked_out, .fast_capture_en_out);

//--- verilog/spsl_defs.svh
// Constants for the serial port selection and lock block.
// Assumes inclusion by the package and the design modules only.
`ifndef SPSL_DEFS_SVH
`define SPSL_DEFS_SVH
`define SPSL_ADDR_W          16
`define SPSL_DATA_W          8
`define SPSL_ADDR_DIE_VER    16'hE707
`define SPSL_ADDR_PORT_CFG   16'hEA00
`define SPSL_CFG_LOCK_BIT    0
`define SPSL_CFG_RESET       8'h00
`define SPSL_EDGES_FOR_SPI   2'h3
`define SPSL_DIE_VERSION     8'h5A
`define SPSL_CAPTURE_REGS    5'h10
`define SPSL_CAP_IDX_W       4
`endif

//--- verilog/spsl_pkg.sv
// Types for the serial port selection and lock block.
// Assumes spsl_defs.svh is on the include path.
`include "spsl_defs.svh"
package spsl_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  typedef enum logic [1:0] {
    SPSL_PORT_NONE,
    SPSL_PORT_I2C,
    SPSL_PORT_SPI
  } spsl_port_t;

  typedef struct packed {
    logic                      wr;
    logic                      rd;
    logic [`SPSL_ADDR_W-1:0]   addr;
    logic [`SPSL_DATA_W-1:0]   wdata;
  } spsl_req_t;

  typedef struct packed {
    logic                      ack;
    logic                      hit;
    logic [`SPSL_DATA_W-1:0]   rdata;
  } spsl_rsp_t;
endpackage

//--- verilog/spsl_sync.sv
// Two-flop synchroniser for one pin level.
// Assumes an asynchronous pin and a single core clock.
module spsl_sync (
  input  wire logic core_clk_in,
  input  wire logic rst_b_in,
  input  wire logic async_in,
  output logic      sync_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic meta_r;
  logic meta_nxt;
  logic sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // Reset to high: the select pin idles high, no false edge at release
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r   <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta_r   <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end
endmodule

//--- verilog/spsl_top.sv
// Host serial port selection, locking and small register set.
// Assumes the protocol engines deliver decoded register requests on
// the core clock and consume the port enables this block drives.
//
// How it works
// - Only two arrangements exist: SPI alone, or I2C with capture.
// - After any reset the fast capture port is disabled.
// - I2C becomes the active port in the first cycle after reset, whatever the select pin level.
// - Three high-to-low select edges after reset make SPI active.
// - Setting the lock bit under I2C freezes the pin and bars SPI.
// - Any write to port config under SPI locks SPI until reset or power down.
// - An 8-bit read-only die version register sits at its address.
// - Registers are written and read through the active port.
// - The capture port streams up to sixteen measurement registers.
`include "spsl_defs.svh"
module spsl_top (
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_b_in,
  input  wire logic                          port_select_pin_in,
  input  wire logic                          power_down_in,
  input  wire spsl_pkg::spsl_req_t           i2c_req_in,
  input  wire spsl_pkg::spsl_req_t           spi_req_in,
  input  wire logic                          cap_en_req_in,
  output spsl_pkg::spsl_rsp_t                rsp_out,
  output logic                               i2c_active_out,
  output logic                               spi_active_out,
  output logic                               port_locked_out,
  output logic                               fast_capture_en_out,
  output logic [`SPSL_CAP_IDX_W-1:0]         cap_reg_idx_out,
  output logic [`SPSL_DATA_W-1:0]            port_config_reg_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Select pin after the synchroniser, and its delayed copy
  logic                          pin_s;
  logic                          pin_d_r;
  logic                          pin_d_nxt;
  logic                          fall;
  // Request of the active port only
  spsl_pkg::spsl_req_t           req;
  logic                          cfg_wr;
  // Port choice and locks
  logic [1:0]                    edge_cnt_r;
  logic [1:0]                    edge_cnt_nxt;
  spsl_pkg::spsl_port_t          port_r;
  spsl_pkg::spsl_port_t          port_nxt;
  logic                          i2c_lock_r;
  logic                          i2c_lock_nxt;
  logic                          spi_lock_r;
  logic                          spi_lock_nxt;
  logic                          sel_open;
  logic                          sel_open_nxt;
  // Register contents and reply
  logic [`SPSL_DATA_W-1:0]       cfg_nxt;
  spsl_pkg::spsl_rsp_t           rsp_nxt;
  // Status levels
  logic                          i2c_act_nxt;
  logic                          spi_act_nxt;
  logic                          locked_nxt;
  // Capture enable and slot index
  logic                          cap_en_nxt;
  logic [`SPSL_CAP_IDX_W-1:0]    cap_idx_nxt;

  spsl_sync u_sync (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .async_in    (port_select_pin_in),
    .sync_out    (pin_s)
  );

  // Falling select edge, in the same cycle as the synchroniser output falls
  always_comb begin
    pin_d_nxt = pin_s;
    fall      = pin_d_r & ~pin_s;
  end

  // Idle-high reset so that release never looks like an edge
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_d_r <= 1'b1;
    end else begin
      pin_d_r <= pin_d_nxt;
    end
  end

  always_comb begin
    unique case (port_r)
      spsl_pkg::SPSL_PORT_NONE: req = '0;
      spsl_pkg::SPSL_PORT_I2C:  req = i2c_req_in;
      spsl_pkg::SPSL_PORT_SPI:  req = spi_req_in;
      default:                  req = '0;
    endcase
    cfg_wr = req.wr && (req.addr == `SPSL_ADDR_PORT_CFG);
  end

  always_comb begin
    edge_cnt_nxt = edge_cnt_r;
    port_nxt     = port_r;
    i2c_lock_nxt = i2c_lock_r;
    spi_lock_nxt = spi_lock_r;
    sel_open     = !i2c_lock_r && !spi_lock_r;
    if (sel_open && fall && edge_cnt_r != `SPSL_EDGES_FOR_SPI) begin
      edge_cnt_nxt = edge_cnt_r + 2'h1;
    end
    if (cfg_wr) begin
      if (port_r == spsl_pkg::SPSL_PORT_SPI) begin
        spi_lock_nxt = 1'b1;
      end else if (req.wdata[`SPSL_CFG_LOCK_BIT]) begin
        i2c_lock_nxt = 1'b1;
      end
    end
    // A lock written in the cycle of the third edge still wins
    sel_open_nxt = !i2c_lock_nxt && !spi_lock_nxt;
    if (port_r == spsl_pkg::SPSL_PORT_NONE) begin
      port_nxt = spsl_pkg::SPSL_PORT_I2C;
    end
    if (sel_open_nxt && edge_cnt_nxt == `SPSL_EDGES_FOR_SPI) begin
      port_nxt = spsl_pkg::SPSL_PORT_SPI;
    end
    if (power_down_in) begin
      edge_cnt_nxt = 2'h0;
      port_nxt     = spsl_pkg::SPSL_PORT_NONE;
      i2c_lock_nxt = 1'b0;
      spi_lock_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      edge_cnt_r <= 2'h0;
      port_r     <= spsl_pkg::SPSL_PORT_NONE;
      i2c_lock_r <= 1'b0;
      spi_lock_r <= 1'b0;
    end else begin
      edge_cnt_r <= edge_cnt_nxt;
      port_r     <= port_nxt;
      i2c_lock_r <= i2c_lock_nxt;
      spi_lock_r <= spi_lock_nxt;
    end
  end

  // The whole byte is kept; under I2C only the lock bit acts, under SPI any write locks
  always_comb begin
    cfg_nxt = port_config_reg_out;
    if (cfg_wr) begin
      cfg_nxt = req.wdata;
    end
    if (power_down_in) begin
      cfg_nxt = `SPSL_CFG_RESET;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_config_reg_out <= `SPSL_CFG_RESET;
    end else begin
      port_config_reg_out <= cfg_nxt;
    end
  end

  always_comb begin
    rsp_nxt     = '0;
    rsp_nxt.ack = req.wr | req.rd;
    if (req.rd) begin
      if (req.addr == `SPSL_ADDR_DIE_VER) begin
        rsp_nxt.hit   = 1'b1;
        rsp_nxt.rdata = `SPSL_DIE_VERSION;
      end else if (req.addr == `SPSL_ADDR_PORT_CFG) begin
        rsp_nxt.hit   = 1'b1;
        rsp_nxt.rdata = port_config_reg_out;
      end
    end else if (cfg_wr) begin
      rsp_nxt.hit = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsp_out <= '0;
    end else begin
      rsp_out <= rsp_nxt;
    end
  end

  // Status levels follow the next port so they line up with the reply
  always_comb begin
    i2c_act_nxt = (port_nxt == spsl_pkg::SPSL_PORT_I2C);
    spi_act_nxt = (port_nxt == spsl_pkg::SPSL_PORT_SPI);
    locked_nxt  = i2c_lock_nxt | spi_lock_nxt;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      i2c_active_out  <= 1'b0;
      spi_active_out  <= 1'b0;
      port_locked_out <= 1'b0;
    end else begin
      i2c_active_out  <= i2c_act_nxt;
      spi_active_out  <= spi_act_nxt;
      port_locked_out <= locked_nxt;
    end
  end

  always_comb begin
    // Off in the first cycle after reset, whatever is asked
    cap_en_nxt = cap_en_req_in && !power_down_in &&
                 (port_r == spsl_pkg::SPSL_PORT_I2C) &&
                 (port_nxt == spsl_pkg::SPSL_PORT_I2C);
    cap_idx_nxt = 4'h0;
    if (fast_capture_en_out) begin
      cap_idx_nxt = cap_reg_idx_out + 4'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fast_capture_en_out <= 1'b0;
      cap_reg_idx_out     <= 4'h0;
    end else begin
      fast_capture_en_out <= cap_en_nxt;
      cap_reg_idx_out     <= cap_idx_nxt;
    end
  end
endmodule
